// ===== verilog/patch_trap_pkg.sv
// constants shared by the program address patch trap unit
// assumes byte-wide register port with 16-bit addresses
package patch_trap_pkg;

  localparam int unsigned ADDR_WIDTH = 16;
  localparam int unsigned PC_WIDTH   = 24;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned CHANNELS   = 2;

  // register offsets
  localparam logic [15:0] PATCH_CONTROL_OFFSET      = 16'h009e;
  localparam logic [15:0] PATCH_ADDRESS_ZERO_OFFSET = 16'h1ff0;
  localparam logic [15:0] PATCH_ADDRESS_ONE_OFFSET  = 16'h1ff3;
  localparam logic [15:0] TRAP_STATUS_OFFSET        = 16'h1ff6;
  localparam logic [15:0] TRAP_MASK_OFFSET          = 16'h1ff7;
  localparam logic [15:0] TRAP_CAPTURE_OFFSET       = 16'h1ff8;

  // control field positions
  localparam int unsigned CHANNEL_ZERO_ENABLE_BIT = 1;
  localparam int unsigned CHANNEL_ONE_ENABLE_BIT  = 3;

  // values after reset
  localparam logic [7:0]  PATCH_CONTROL_RESET = 8'h00;
  localparam logic [1:0]  TRAP_STATUS_RESET   = 2'h0;
  localparam logic [1:0]  TRAP_MASK_RESET     = 2'h0;
  localparam logic [23:0] PATCH_ADDRESS_RESET = 24'h000000;

  // opcode forced onto the fetch bus on a hit
  localparam logic [7:0] TRAP_OPCODE = 8'h01;

  // one enable per byte of a three byte register starting at base
  function automatic logic [2:0] byte_select(input logic [15:0] addr,
                                             input logic [15:0] base);
    logic [2:0] sel;
    sel = 3'h0;
    if (addr == base) begin
      sel = 3'h1;
    end
    if (addr == base + 16'h0001) begin
      sel = 3'h2;
    end
    if (addr == base + 16'h0002) begin
      sel = 3'h4;
    end
    return sel;
  endfunction : byte_select

endpackage : patch_trap_pkg

// ===== verilog/patch_channel.sv
// one address compare channel: a 24-bit byte-written address and its comparator
// assumes the pc arrives from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module patch_channel (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [2:0]  byte_wr,
  input  wire logic [7:0]  wdata,
  input  wire logic        compare_enable,
  input  wire logic [23:0] pc,
  output logic      [23:0] address,
  output logic             hit
);

  logic [23:0] address_reg;

  // each byte lands alone, so a partly rewritten address matches on what is stored
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      address_reg <= patch_trap_pkg::PATCH_ADDRESS_RESET;
    end else begin
      if (byte_wr[0]) begin
        address_reg[7:0] <= wdata;
      end
      if (byte_wr[1]) begin
        address_reg[15:8] <= wdata;
      end
      if (byte_wr[2]) begin
        address_reg[23:16] <= wdata;
      end
    end
  end

  assign address = address_reg;
  // full width compare, gated by the channel enable
  assign hit = compare_enable && (address_reg == pc);

endmodule : patch_channel
`default_nettype wire

// ===== verilog/patch_event_irq.sv
// sticky event status with write-one-to-clear, mask and one level interrupt
// assumes events are single cycle pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module patch_event_irq (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] event_in,
  input  wire logic       status_wr,
  input  wire logic       mask_wr,
  input  wire logic [1:0] wdata,
  output logic      [1:0] status,
  output logic      [1:0] mask,
  output logic            irq
);

  logic [1:0] status_reg;
  logic [1:0] mask_reg;

  // a new event wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      status_reg <= patch_trap_pkg::TRAP_STATUS_RESET;
    end else if (status_wr) begin
      status_reg <= (status_reg & ~wdata) | event_in;
    end else begin
      status_reg <= status_reg | event_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mask_reg <= patch_trap_pkg::TRAP_MASK_RESET;
    end else if (mask_wr) begin
      mask_reg <= wdata;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = |(status_reg & mask_reg);

endmodule : patch_event_irq
`default_nettype wire

// ===== verilog/program_address_patch_trap.sv
// program address patch trap: two channels force a trap opcode onto the fetch bus
// assumes a byte register port and a fetch path on the same sys_clk
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module program_address_patch_trap (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        fetch_valid,
  input  wire logic [23:0] fetch_pc,
  input  wire logic [7:0]  fetch_data_in,
  output logic             fetch_out_valid,
  output logic      [7:0]  fetch_data_out,
  output logic             forced_patch_trap,
  output logic             irq
);

  logic [7:0]  patch_control_reg;
  logic        channel_zero_compare_enable;
  logic        channel_one_compare_enable;
  logic [2:0]  sel_zero;
  logic [2:0]  sel_one;
  logic [2:0]  sel_capture;
  logic [2:0]  wr_zero;
  logic [2:0]  wr_one;
  logic [23:0] address_zero;
  logic [23:0] address_one;
  logic        hit_zero;
  logic        hit_one;
  logic        any_hit;
  logic [1:0]  trap_event;
  logic [1:0]  status;
  logic [1:0]  mask;
  logic        ctrl_hit;
  logic        status_hit;
  logic        mask_hit;
  logic [23:0] capture_reg;
  logic        fetch_out_valid_reg;
  logic [7:0]  fetch_data_out_reg;
  logic        forced_patch_trap_reg;
  logic [7:0]  reg_rdata_reg;
  logic [7:0]  reg_rdata_next;

  // address decode
  assign sel_zero    = patch_trap_pkg::byte_select(reg_addr,
                         patch_trap_pkg::PATCH_ADDRESS_ZERO_OFFSET);
  assign sel_one     = patch_trap_pkg::byte_select(reg_addr,
                         patch_trap_pkg::PATCH_ADDRESS_ONE_OFFSET);
  assign sel_capture = patch_trap_pkg::byte_select(reg_addr,
                         patch_trap_pkg::TRAP_CAPTURE_OFFSET);
  assign ctrl_hit    = (reg_addr == patch_trap_pkg::PATCH_CONTROL_OFFSET);
  assign status_hit  = (reg_addr == patch_trap_pkg::TRAP_STATUS_OFFSET);
  assign mask_hit    = (reg_addr == patch_trap_pkg::TRAP_MASK_OFFSET);
  assign wr_zero     = reg_wr ? sel_zero : 3'h0;
  assign wr_one      = reg_wr ? sel_one : 3'h0;

  // only the two enables are stored; reserved bits read zero whatever is written
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      patch_control_reg <= patch_trap_pkg::PATCH_CONTROL_RESET;
    end else if (reg_wr && ctrl_hit) begin
      patch_control_reg <= 8'h00;
      patch_control_reg[patch_trap_pkg::CHANNEL_ONE_ENABLE_BIT] <=
        reg_wdata[patch_trap_pkg::CHANNEL_ONE_ENABLE_BIT];
      patch_control_reg[patch_trap_pkg::CHANNEL_ZERO_ENABLE_BIT] <=
        reg_wdata[patch_trap_pkg::CHANNEL_ZERO_ENABLE_BIT];
    end
  end

  assign channel_zero_compare_enable =
    patch_control_reg[patch_trap_pkg::CHANNEL_ZERO_ENABLE_BIT];
  assign channel_one_compare_enable =
    patch_control_reg[patch_trap_pkg::CHANNEL_ONE_ENABLE_BIT];

  // rewriting an enabled channel is allowed but may trap on a half-new address
  patch_channel u_channel_zero (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .byte_wr        (wr_zero),
    .wdata          (reg_wdata),
    .compare_enable (channel_zero_compare_enable),
    .pc             (fetch_pc),
    .address        (address_zero),
    .hit            (hit_zero)
  );

  patch_channel u_channel_one (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .byte_wr        (wr_one),
    .wdata          (reg_wdata),
    .compare_enable (channel_one_compare_enable),
    .pc             (fetch_pc),
    .address        (address_one),
    .hit            (hit_one)
  );

  assign trap_event = fetch_valid ? {hit_one, hit_zero} : 2'h0;
  assign any_hit    = |trap_event;

  // fetch path is one register stage so the forced byte comes from a flop
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fetch_out_valid_reg <= 1'b0;
    end else begin
      fetch_out_valid_reg <= fetch_valid;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fetch_data_out_reg <= 8'h00;
    end else if (fetch_valid) begin
      fetch_data_out_reg <= any_hit ? patch_trap_pkg::TRAP_OPCODE : fetch_data_in;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      forced_patch_trap_reg <= 1'b0;
    end else begin
      forced_patch_trap_reg <= any_hit;
    end
  end

  // last trapped pc, for software that cannot see the stacked counter
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      capture_reg <= patch_trap_pkg::PATCH_ADDRESS_RESET;
    end else if (any_hit) begin
      capture_reg <= fetch_pc;
    end
  end

  patch_event_irq u_event_irq (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .event_in  (trap_event),
    .status_wr (reg_wr && status_hit),
    .mask_wr   (reg_wr && mask_hit),
    .wdata     (reg_wdata[1:0]),
    .status    (status),
    .mask      (mask),
    .irq       (irq)
  );

  // read mux; unmapped addresses read zero
  always_comb begin
    reg_rdata_next = 8'h00;
    if (ctrl_hit) begin
      reg_rdata_next = patch_control_reg;
    end
    if (status_hit) begin
      reg_rdata_next = {6'h00, status};
    end
    if (mask_hit) begin
      reg_rdata_next = {6'h00, mask};
    end
    if (sel_zero[0]) begin
      reg_rdata_next = address_zero[7:0];
    end
    if (sel_zero[1]) begin
      reg_rdata_next = address_zero[15:8];
    end
    if (sel_zero[2]) begin
      reg_rdata_next = address_zero[23:16];
    end
    if (sel_one[0]) begin
      reg_rdata_next = address_one[7:0];
    end
    if (sel_one[1]) begin
      reg_rdata_next = address_one[15:8];
    end
    if (sel_one[2]) begin
      reg_rdata_next = address_one[23:16];
    end
    if (sel_capture[0]) begin
      reg_rdata_next = capture_reg[7:0];
    end
    if (sel_capture[1]) begin
      reg_rdata_next = capture_reg[15:8];
    end
    if (sel_capture[2]) begin
      reg_rdata_next = capture_reg[23:16];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_reg <= reg_rdata_next;
    end else begin
      reg_rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata         = reg_rdata_reg;
  assign fetch_out_valid   = fetch_out_valid_reg;
  assign fetch_data_out    = fetch_data_out_reg;
  assign forced_patch_trap = forced_patch_trap_reg;

endmodule : program_address_patch_trap
`default_nettype wire

// ===== testbench/cpu_fetch_model.sv
// cpu fetch path model: issues one opcode fetch per commanded cycle
// assumes commands change just after a rising sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module cpu_fetch_model (
  input  wire logic        sys_clk,
  input  wire logic        req,
  input  wire logic [23:0] req_pc,
  input  wire logic [7:0]  req_byte,
  output logic             fetch_valid = 1'b0,
  output logic      [23:0] fetch_pc = 24'h000000,
  output logic      [7:0]  fetch_data_in = 8'h00
);
  // idle cycles show inverted values so a stale fetch never looks valid
  always @(posedge sys_clk) begin
    fetch_valid <= req;
    fetch_pc <= req ? req_pc : ~fetch_pc;
    fetch_data_in <= req ? req_byte : ~fetch_data_in;
  end
endmodule : cpu_fetch_model
`default_nettype wire

// ===== testbench/program_address_patch_trap_properties.sv
// port assertions for the program address patch trap
// assumes one sys_clk domain with synchronous active low rstn
`timescale 1ns/1ps
`default_nettype none
module program_address_patch_trap_properties (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        fetch_valid,
  input wire logic [23:0] fetch_pc,
  input wire logic [7:0]  fetch_data_in,
  input wire logic        fetch_out_valid,
  input wire logic [7:0]  fetch_data_out,
  input wire logic        forced_patch_trap,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == patch_trap_pkg::PATCH_CONTROL_OFFSET;
  sequence ctrl_off;
    ctl_wr && !reg_wdata[3] && !reg_wdata[1];
  endsequence
  sequence quiet_fetch;
    (!ctl_wr)[*3] ##1 fetch_valid;
  endsequence
  chk_out_follows: assert property (fetch_valid |=> fetch_out_valid)
    else $error("no output valid after fetch");
  chk_no_fetch_idle: assert property (!fetch_valid |=> !fetch_out_valid && !forced_patch_trap)
    else $error("output without fetch");
  chk_trap_opcode: assert property (forced_patch_trap |-> fetch_data_out == 8'h01)
    else $error("trap without opcode 01");
  chk_pass_through: assert property (fetch_valid ##1 !forced_patch_trap |->
    fetch_data_out == $past(fetch_data_in)) else $error("fetch byte altered");
  chk_disabled_quiet: assert property (ctrl_off ##1 quiet_fetch |=> !forced_patch_trap)
    else $error("trap while disabled");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_ctrl_reserved: assert property (reg_rd && reg_addr == 16'h009e |=>
    (reg_rdata & 8'hf5) == 8'h00) else $error("control reserved bit set");
  chk_low_unmapped: assert property (reg_rd && reg_addr < 16'h009e |=> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");
  chk_mask_off_irq: assert property (reg_wr && reg_addr == 16'h1ff7 && reg_wdata[1:0] == 2'h0
    |=> !irq) else $error("irq with mask clear");
endmodule : program_address_patch_trap_properties
bind program_address_patch_trap program_address_patch_trap_properties u_props (
  .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fetch_valid(fetch_valid),
  .fetch_pc(fetch_pc), .fetch_data_in(fetch_data_in), .fetch_out_valid(fetch_out_valid),
  .fetch_data_out(fetch_data_out), .forced_patch_trap(forced_patch_trap), .irq(irq));
`default_nettype wire

// ===== testbench/program_address_patch_trap_tb.sv
// self-checking bench for the program address patch trap
// assumes the checker binds itself; the fetch model stands in for the cpu
`timescale 1ns/1ps
`default_nettype none
module program_address_patch_trap_tb;
  localparam logic [15:0] CTL = patch_trap_pkg::PATCH_CONTROL_OFFSET;
  localparam logic [15:0] STS = patch_trap_pkg::TRAP_STATUS_OFFSET;
  localparam logic [15:0] MSK = patch_trap_pkg::TRAP_MASK_OFFSET;
  logic        sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, req = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0]  reg_wdata = 8'h00, req_byte = 8'h00, reg_rdata, fetch_data_in, fetch_data_out;
  logic [23:0] req_pc = 24'h000000, fetch_pc, addr0, addr1;
  logic        fetch_valid, fetch_out_valid, forced_patch_trap, irq, pend = 1'b0, pend_hit;
  logic [7:0]  pend_data;
  logic [23:0] last_pc;
  logic [1:0]  en = 2'h0, seen = 2'h0;
  int          err_total = 0, checked = 0, cycles = 0, seed;
  always #2 sys_clk = ~sys_clk;
  program_address_patch_trap u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fetch_valid(fetch_valid), .fetch_pc(fetch_pc), .fetch_data_in(fetch_data_in),
    .fetch_out_valid(fetch_out_valid), .fetch_data_out(fetch_data_out),
    .forced_patch_trap(forced_patch_trap), .irq(irq));
  cpu_fetch_model u_cpu (.sys_clk(sys_clk), .req(req), .req_pc(req_pc), .req_byte(req_byte),
    .fetch_valid(fetch_valid), .fetch_pc(fetch_pc), .fetch_data_in(fetch_data_in));
  function automatic logic [1:0] hit_of(input logic [23:0] pc);
    return {en[1] && pc === addr1, en[0] && pc === addr0};
  endfunction : hit_of
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check8
  task automatic final_report;
    $display("checked=%0d err_total=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    check8(reg_rdata, exp);
  endtask : rd
  task automatic irq_is(input logic exp);
    @(negedge sys_clk);
    check8({7'h0, irq}, {7'h0, exp});
  endtask : irq_is
  task automatic set_ctl(input logic [7:0] d);
    wr(CTL, d);
    en = {d[3], d[1]};
  endtask : set_ctl
  task automatic set_addr(input logic ch, input logic [23:0] a);
    logic [15:0] base;
    base = ch ? patch_trap_pkg::PATCH_ADDRESS_ONE_OFFSET : patch_trap_pkg::PATCH_ADDRESS_ZERO_OFFSET;
    for (int i = 0; i < 3; i++) wr(base + 16'(i), a[8*i +: 8]);
    for (int i = 0; i < 3; i++) rd(base + 16'(i), a[8*i +: 8]);
    if (ch) addr1 = a;
    else addr0 = a;
  endtask : set_addr
  // back-to-back fetches near both stored addresses, some one bit off
  task automatic burst(input int n);
    logic [1:0] sel;
    for (int i = 0; i < n; i++) begin
      sel = 2'($urandom_range(3));
      @(posedge sys_clk);
      req <= 1'b1;
      req_byte <= 8'($urandom);
      req_pc <= (sel[0] ? addr1 : addr0) ^ (sel[1] ? 24'h1 << $urandom_range(23) : 24'h0);
    end
    @(posedge sys_clk);
    req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : burst
  always @(posedge sys_clk) begin
    pend <= rstn && fetch_valid;
    pend_hit <= |hit_of(fetch_pc);
    pend_data <= |hit_of(fetch_pc) ? 8'h01 : fetch_data_in;
    seen <= seen | ((rstn && fetch_valid) ? hit_of(fetch_pc) : 2'h0);
    // the capture register keeps the pc of the most recent trapped fetch
    if (rstn && fetch_valid && |hit_of(fetch_pc)) last_pc <= fetch_pc;
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_total++;
      final_report();
    end
  end
  always @(negedge sys_clk) begin
    if (rstn) begin
      check8({7'h0, fetch_out_valid}, {7'h0, pend});
      check8({7'h0, forced_patch_trap}, {7'h0, pend && pend_hit});
      if (pend) check8(fetch_data_out, pend_data);
    end
  end
  initial begin
    seed = $urandom(32'h60ee);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(CTL, 8'h00);
    rd(STS, 8'h00);
    rd(16'h0010, 8'h00);
    set_ctl(8'hcf);
    rd(CTL, 8'h0a);
    set_ctl(8'h00);
    set_addr(1'b0, 24'($urandom));
    set_addr(1'b1, 24'($urandom));
    burst(20);
    $display("test registers and disabled channels done");
    set_ctl(8'h02);
    burst(30);
    set_ctl(8'h08);
    burst(30);
    set_ctl(8'h00);
    // fetches right after disabling: matching pcs must pass untouched
    burst(8);
    wr(16'h1ff1, ~addr0[15:8]);
    addr0[15:8] = ~addr0[15:8];
    set_ctl(8'h0a);
    burst(30);
    $display("test enabled channels done");
    rd(STS, {6'h0, seen});
    for (int i = 0; i < 3; i++) rd(patch_trap_pkg::TRAP_CAPTURE_OFFSET + 16'(i), last_pc[8*i +: 8]);
    wr(MSK, 8'h01);
    irq_is(seen[0]);
    wr(STS, 8'h01);
    irq_is(1'b0);
    wr(MSK, 8'h03);
    irq_is(seen[1]);
    wr(STS, 8'h02);
    rd(STS, 8'h00);
    wr(MSK, 8'h00);
    irq_is(1'b0);
    $display("test interrupt done");
    final_report();
  end
endmodule : program_address_patch_trap_tb
`default_nettype wire
